/* verilog/vsc_pkg.sv */
// constants and carrier types shared by the video scaler block
package vsc_pkg;
  localparam int FIFO_DEPTH = 1280;
  localparam int LVL_W = 11;
  localparam int LUT_N = 48;
  localparam int LUT_IDX_W = 6;
  localparam int CR_W = 20;
  localparam int SUM_W = 14;
  localparam int CNT_W = 7;
  localparam int THR_SHIFT = 3;
  localparam int WT_SHIFT = 6;
  // one whole output step is 64.00 in hundredths
  localparam logic [CR_W-1:0] PHASE_ONE = 20'h0_1900;
  localparam logic [CR_W-1:0] PCT_SCALE = 20'h0_0064;
  localparam logic [7:0] WEIGHT_MAX = 8'h40;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_THR = 8'h04;
  localparam logic [7:0] OFF_DSC_H = 8'h08;
  localparam logic [7:0] OFF_DSC_V = 8'h0c;
  localparam logic [7:0] OFF_USC_H = 8'h10;
  localparam logic [7:0] OFF_USC_V = 8'h14;
  localparam logic [7:0] OFF_LUT = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1c;
  // field positions
  localparam int CTRL_DSC_EN = 0;
  localparam int CTRL_USC_EN = 1;
  localparam int CTRL_LINE_HOLD = 2;
  localparam int CTRL_DSC_MIRROR = 3;
  localparam int CTRL_USC_MIRROR = 4;
  localparam int CTRL_W = 5;
  localparam int CORR_LSB = 16;
  localparam int CORR_W = 7;
  localparam int DSC_INCR_W = 7;
  localparam int USC_INCR_W = 13;
  localparam int LUT_IDX_LSB = 8;
  localparam int LUT_SEL_BIT = 16;
  localparam int STAT_LOCK_BIT = 16;
  // values after reset
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [7:0] THR_RST = 8'h00;
  localparam logic [DSC_INCR_W-1:0] DSC_INCR_RST = 7'h40;
  localparam logic [USC_INCR_W-1:0] USC_INCR_RST = 13'h0040;
  localparam logic [CORR_W-1:0] CORR_RST = 7'h00;

  typedef struct packed {
    logic sof;
    logic sol;
    logic [2:0][7:0] rgb;
  } vsc_pix_t;

  typedef struct packed {
    vsc_pix_t pix;
    logic [6:0] vRepeat;
    logic [7:0] vWeight;
    logic mirror;
  } vsc_out_t;

  typedef enum logic [1:0] {
    US_LOAD = 2'b01,
    US_EMIT = 2'b10
  } vsc_us_state_t;
endpackage : vsc_pkg

/* verilog/vsc_scaler.sv */
// video scaler: decoupling line fifo, downscaler, upscaler and apb registers
// What this block does
// [RULE_01] buffer holds up to 1280 pixels
// [RULE_02] lock output per line or per frame
// [RULE_03] release when level exceeds threshold times eight
// [RULE_04] downscale by accumulation, down to 1/64
// [RULE_05] downscaler works only when enabled
// [RULE_06] independent downscale steps, integer plus hundredths
// [RULE_07] independent upscale steps, up to 64x
// [RULE_08] interpolate through programmable transition shape
// [RULE_09] 48 entry table of values 0..64
// [RULE_10] separate tables for horizontal and vertical
// [RULE_11] upscaler works only when enabled
// [RULE_12] upscale step integer plus hundredths correction
// [RULE_13] only whole output lines, fraction dropped; the code carries the fraction into the next line's credit
// [RULE_14] downscaler mirror disables vertical downscaling
// [RULE_15] software mirrors in upscaler when also downscaling
// [RULE_16] step accumulators restart each line and frame
//
// Added by the designer: the APB register port and the register addresses.

module vsc_line_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 1280,
  parameter int LVL_W = 11
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady,
  output logic [LVL_W-1:0] level
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [LVL_W-1:0] wrPtr;
  logic [LVL_W-1:0] rdPtr;
  logic [LVL_W-1:0] next_level;
  logic push;
  logic pop;

  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outValid = (level != '0);
  assign outData = mem[rdPtr];
  assign next_level = level + LVL_W'(push) - LVL_W'(pop);

  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem[wrPtr] <= inData;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      level <= '0;
      inReady <= 1'b0;
    end
    else
    begin
      if (push)
        wrPtr <= (wrPtr == LVL_W'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      if (pop)
        rdPtr <= (rdPtr == LVL_W'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      level <= next_level;
      inReady <= (next_level != LVL_W'(DEPTH)); // see [RULE_01]
    end
  end
endmodule : vsc_line_fifo

module vsc_scaler (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic inValid,
  input wire vsc_pkg::vsc_pix_t inData,
  output logic inReady,
  output logic outValid,
  output vsc_pkg::vsc_out_t outData,
  input wire logic outReady
);
  localparam int ONE_I = int'(vsc_pkg::PHASE_ONE);

  logic [vsc_pkg::CTRL_W-1:0] ctrl;
  logic [7:0] thr;
  logic [vsc_pkg::DSC_INCR_W-1:0] dscHIncr, dscVIncr;
  logic [vsc_pkg::USC_INCR_W-1:0] uscHIncr, uscVIncr;
  logic [vsc_pkg::CORR_W-1:0] dscHCorr, dscVCorr, uscHCorr, uscVCorr;
  logic [7:0] hLut [vsc_pkg::LUT_N];
  logic [7:0] vLut [vsc_pkg::LUT_N];
  logic [vsc_pkg::LUT_IDX_W-1:0] lutIdx;
  logic lutSel;
  logic dscEn, uscEn, lineHold, dscMirror, uscMirror;
  logic [vsc_pkg::CR_W-1:0] dscHStep, dscVStep, uscHStep, uscVStep;

  function automatic logic [vsc_pkg::CR_W-1:0] stepOf(input logic [12:0] incr,
                                                    input logic [6:0] corr);
    stepOf = vsc_pkg::CR_W'(incr) * vsc_pkg::PCT_SCALE + vsc_pkg::CR_W'(corr);
  endfunction : stepOf

  assign dscEn = ctrl[vsc_pkg::CTRL_DSC_EN];
  assign uscEn = ctrl[vsc_pkg::CTRL_USC_EN];
  assign lineHold = ctrl[vsc_pkg::CTRL_LINE_HOLD];
  assign dscMirror = ctrl[vsc_pkg::CTRL_DSC_MIRROR];
  assign uscMirror = ctrl[vsc_pkg::CTRL_USC_MIRROR];
  assign dscHStep = stepOf(13'(dscHIncr), dscHCorr); // see [RULE_06]
  assign dscVStep = stepOf(13'(dscVIncr), dscVCorr); // see [RULE_06]
  assign uscHStep = stepOf(uscHIncr, uscHCorr); // see [RULE_12]
  assign uscVStep = stepOf(uscVIncr, uscVCorr); // see [RULE_12]

  // decoupling fifo and its output lock
  vsc_pkg::vsc_pix_t head;
  logic headValid, fifoPop, headBlocks, released, dsReady;
  logic [vsc_pkg::LVL_W-1:0] level;
  logic [vsc_pkg::LVL_W-1:0] relLevel;

  vsc_line_fifo #(
    .WIDTH($bits(vsc_pkg::vsc_pix_t)),
    .DEPTH(vsc_pkg::FIFO_DEPTH),
    .LVL_W(vsc_pkg::LVL_W)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .inValid(inValid),
    .inData(inData),
    .inReady(inReady),
    .outValid(headValid),
    .outData(head),
    .outReady(fifoPop),
    .level(level)
  );

  assign relLevel = vsc_pkg::LVL_W'({thr, 3'b000});
  assign headBlocks = headValid && (lineHold ? head.sol : head.sof); // see [RULE_02]
  assign fifoPop = headValid && dsReady && (!headBlocks || released);

  // a frame shorter than the release level stalls until more data arrives
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      released <= 1'b0;
    else if (fifoPop)
      released <= 1'b0;
    else if (headBlocks && (level > relLevel))
      released <= 1'b1; // see [RULE_03]
  end

  // downscaler: horizontal pixel accumulation, vertical line selection
  logic dsValid, dsTake, lineKeep, pendSof, pendSol;
  vsc_pkg::vsc_pix_t dsPix;
  logic [vsc_pkg::CR_W-1:0] dHCredit, dVCredit, next_dHCredit, next_dVCredit;
  logic [2:0][vsc_pkg::SUM_W-1:0] dSum, next_dSum;
  logic [2:0][7:0] dAvg;
  logic [vsc_pkg::CNT_W-1:0] dCnt, next_dCnt;
  logic next_lineKeep, dEmit;

  always_comb
  begin
    logic [vsc_pkg::CR_W-1:0] vc;
    logic [vsc_pkg::CR_W-1:0] hc;
    vc = (head.sof ? '0 : dVCredit) + dscVStep;
    hc = (head.sol ? '0 : dHCredit) + dscHStep; // see [RULE_16]
    next_lineKeep = lineKeep;
    next_dVCredit = dVCredit;
    if (head.sol)
    begin
      if (dscMirror)
      begin
        next_lineKeep = 1'b1; // see [RULE_14]
        next_dVCredit = '0;
      end
      else if (vc >= vsc_pkg::PHASE_ONE)
      begin
        next_lineKeep = 1'b1;
        next_dVCredit = vc - vsc_pkg::PHASE_ONE;
      end
      else
      begin
        next_lineKeep = 1'b0;
        next_dVCredit = vc;
      end
    end
    dEmit = (hc >= vsc_pkg::PHASE_ONE); // see [RULE_04]
    next_dHCredit = dEmit ? hc - vsc_pkg::PHASE_ONE : hc;
    next_dCnt = (head.sol ? '0 : dCnt) + 1'b1;
  end

  generate
    for (genvar c = 0; c < 3; c++)
    begin : g_dsum
      assign next_dSum[c] = (head.sol ? '0 : dSum[c]) + vsc_pkg::SUM_W'(head.rgb[c]);
      assign dAvg[c] = 8'(next_dSum[c] / vsc_pkg::SUM_W'(next_dCnt)); // see [RULE_04]
    end
  endgenerate

  assign dsReady = !dsValid || dsTake;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      dsValid <= 1'b0;
      dsPix <= '0;
      dHCredit <= '0;
      dVCredit <= '0;
      dSum <= '0;
      dCnt <= '0;
      lineKeep <= 1'b1;
      pendSof <= 1'b0;
      pendSol <= 1'b0;
    end
    else
    begin
      if (dsTake)
        dsValid <= 1'b0;
      if (fifoPop && !dscEn)
      begin
        dsValid <= 1'b1; // see [RULE_05]
        dsPix <= head;
      end
      else if (fifoPop)
      begin
        dHCredit <= next_dHCredit;
        dVCredit <= next_dVCredit;
        lineKeep <= next_lineKeep;
        if (dEmit)
        begin
          dSum <= '0;
          dCnt <= '0;
        end
        else
        begin
          dSum <= next_dSum;
          dCnt <= next_dCnt;
        end
        if (dEmit && next_lineKeep)
        begin
          dsValid <= 1'b1;
          dsPix.sof <= pendSof || head.sof;
          dsPix.sol <= pendSol || head.sol;
          dsPix.rgb <= dAvg;
          pendSof <= 1'b0;
          pendSol <= 1'b0;
        end
        else
        begin
          pendSof <= pendSof || head.sof;
          pendSol <= pendSol || head.sol;
        end
      end
    end
  end

  // upscaler: horizontal interpolation, vertical whole-line repeat count
  vsc_pkg::vsc_us_state_t usState;
  vsc_pkg::vsc_pix_t uPrev, uCur;
  logic [vsc_pkg::CR_W-1:0] uCredit, uVCredit, next_uCredit, next_uVCredit, uRemain;
  logic [6:0] next_vRep;
  logic [7:0] next_vWeight, hWeight;
  logic [vsc_pkg::LUT_IDX_W-1:0] hIdx;
  logic [2:0][7:0] uInterp;
  logic uPendSof, uPendSol, canEmit;
  // line repeat and weight wait here so a stalled output word never changes
  logic [6:0] lineRep;
  logic [7:0] lineWeight;

  assign dsTake = (usState == vsc_pkg::US_LOAD) && dsValid;
  assign canEmit = !outValid || outReady;
  assign uRemain = uCredit - vsc_pkg::PHASE_ONE;

  always_comb
  begin
    logic [vsc_pkg::CR_W-1:0] uvc;
    logic [vsc_pkg::CR_W-1:0] vFrac;
    logic [25:0] hPos;
    uvc = (dsPix.sof ? '0 : uVCredit) + uscVStep; // see [RULE_16]
    vFrac = uvc % vsc_pkg::CR_W'(ONE_I);
    hPos = (uscHStep == '0) ? '0 : (26'(uRemain) * 26'(vsc_pkg::LUT_N)) / 26'(uscHStep);
    next_vRep = 7'(uvc / vsc_pkg::CR_W'(ONE_I)); // see [RULE_13]
    next_uVCredit = vFrac;
    next_vWeight = vLut[6'((vFrac * vsc_pkg::CR_W'(vsc_pkg::LUT_N)) / vsc_pkg::CR_W'(ONE_I))];
    next_uCredit = (dsPix.sol ? '0 : uCredit) + (uscEn ? uscHStep : vsc_pkg::PHASE_ONE);
    hIdx = (hPos >= 26'(vsc_pkg::LUT_N)) ? '0 : 6'(vsc_pkg::LUT_N - 1) - 6'(hPos);
    hWeight = hLut[hIdx]; // see [RULE_10]
  end

  generate
    for (genvar c = 0; c < 3; c++)
    begin : g_interp
      assign uInterp[c] = 8'((16'(uPrev.rgb[c]) * 16'(vsc_pkg::WEIGHT_MAX - hWeight)
                            + 16'(uCur.rgb[c]) * 16'(hWeight)) >> vsc_pkg::WT_SHIFT);
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      usState <= vsc_pkg::US_LOAD;
      uPrev <= '0;
      uCur <= '0;
      uCredit <= '0;
      uVCredit <= '0;
      uPendSof <= 1'b0;
      uPendSol <= 1'b0;
      outValid <= 1'b0;
      outData <= '0;
      lineRep <= '0;
      lineWeight <= '0;
    end
    else
    begin
      if (outValid && outReady)
        outValid <= 1'b0;
      case (usState)
        vsc_pkg::US_LOAD:
        begin
          if (dsValid)
          begin
            uCur <= dsPix;
            uPrev <= dsPix.sol ? dsPix : uCur;
            uCredit <= next_uCredit; // see [RULE_12]
            uPendSof <= uPendSof || dsPix.sof;
            uPendSol <= uPendSol || dsPix.sol;
            if (dsPix.sol)
            begin
              uVCredit <= next_uVCredit;
              lineRep <= uscEn ? next_vRep : 7'h01; // see [RULE_13]
              lineWeight <= uscEn ? next_vWeight : vsc_pkg::WEIGHT_MAX;
            end
            if (next_uCredit >= vsc_pkg::PHASE_ONE)
              usState <= vsc_pkg::US_EMIT; // see [RULE_07]
          end
        end
        vsc_pkg::US_EMIT:
        begin
          if (canEmit)
          begin
            outValid <= 1'b1;
            outData.pix.sof <= uPendSof;
            outData.pix.sol <= uPendSol;
            outData.pix.rgb <= uscEn ? uInterp : uCur.rgb; // see [RULE_11]
            outData.mirror <= uscMirror || dscMirror;
            outData.vRepeat <= lineRep;
            outData.vWeight <= lineWeight;
            uPendSof <= 1'b0;
            uPendSol <= 1'b0;
            uCredit <= uRemain;
            if (uRemain < vsc_pkg::PHASE_ONE)
              usState <= vsc_pkg::US_LOAD;
          end
        end
        default:
          usState <= vsc_pkg::US_LOAD;
      endcase
    end
  end

  // apb slave: zero wait, answer one cycle after setup
  logic apbSetup, apbWrite, next_err;
  logic [31:0] next_prdata;

  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pready && pwrite;

  always_comb
  begin
    next_err = 1'b0;
    next_prdata = '0;
    case (paddr)
      vsc_pkg::OFF_CTRL: next_prdata = 32'(ctrl);
      vsc_pkg::OFF_THR: next_prdata = 32'(thr);
      vsc_pkg::OFF_DSC_H: next_prdata = {9'h000, dscHCorr, 9'h000, dscHIncr};
      vsc_pkg::OFF_DSC_V: next_prdata = {9'h000, dscVCorr, 9'h000, dscVIncr};
      vsc_pkg::OFF_USC_H: next_prdata = {9'h000, uscHCorr, 3'h0, uscHIncr};
      vsc_pkg::OFF_USC_V: next_prdata = {9'h000, uscVCorr, 3'h0, uscVIncr};
      vsc_pkg::OFF_LUT: next_prdata = {15'h0000, lutSel, 2'h0, lutIdx,
                                       lutSel ? vLut[lutIdx] : hLut[lutIdx]};
      vsc_pkg::OFF_STAT: next_prdata = {15'h0000, headBlocks && !released,
                                        5'h00, level};
      default: next_err = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= apbSetup;
      pslverr <= apbSetup && next_err;
      if (apbSetup && !pwrite)
        prdata <= next_prdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl <= vsc_pkg::CTRL_RST;
      thr <= vsc_pkg::THR_RST;
      dscHIncr <= vsc_pkg::DSC_INCR_RST;
      dscVIncr <= vsc_pkg::DSC_INCR_RST;
      uscHIncr <= vsc_pkg::USC_INCR_RST;
      uscVIncr <= vsc_pkg::USC_INCR_RST;
      dscHCorr <= vsc_pkg::CORR_RST;
      dscVCorr <= vsc_pkg::CORR_RST;
      uscHCorr <= vsc_pkg::CORR_RST;
      uscVCorr <= vsc_pkg::CORR_RST;
      lutIdx <= '0;
      lutSel <= 1'b0;
    end
    else if (apbWrite)
    begin
      case (paddr)
        vsc_pkg::OFF_CTRL: ctrl <= pwdata[vsc_pkg::CTRL_W-1:0];
        vsc_pkg::OFF_THR: thr <= pwdata[7:0];
        vsc_pkg::OFF_DSC_H:
        begin
          dscHIncr <= pwdata[vsc_pkg::DSC_INCR_W-1:0];
          dscHCorr <= pwdata[vsc_pkg::CORR_LSB +: vsc_pkg::CORR_W];
        end
        vsc_pkg::OFF_DSC_V:
        begin
          dscVIncr <= pwdata[vsc_pkg::DSC_INCR_W-1:0];
          dscVCorr <= pwdata[vsc_pkg::CORR_LSB +: vsc_pkg::CORR_W];
        end
        vsc_pkg::OFF_USC_H:
        begin
          uscHIncr <= pwdata[vsc_pkg::USC_INCR_W-1:0];
          uscHCorr <= pwdata[vsc_pkg::CORR_LSB +: vsc_pkg::CORR_W];
        end
        vsc_pkg::OFF_USC_V:
        begin
          uscVIncr <= pwdata[vsc_pkg::USC_INCR_W-1:0];
          uscVCorr <= pwdata[vsc_pkg::CORR_LSB +: vsc_pkg::CORR_W];
        end
        vsc_pkg::OFF_LUT:
        begin
          if (pwdata[vsc_pkg::LUT_IDX_LSB +: vsc_pkg::LUT_IDX_W] < 6'(vsc_pkg::LUT_N))
          begin
            lutIdx <= pwdata[vsc_pkg::LUT_IDX_LSB +: vsc_pkg::LUT_IDX_W];
            lutSel <= pwdata[vsc_pkg::LUT_SEL_BIT];
          end
        end
        default: ;
      endcase
    end
  end

  // table entries clamp at 64 so weights never exceed unity
  logic [5:0] wrIdx;
  logic [7:0] wrVal;
  logic lutWrite;
  assign wrIdx = pwdata[vsc_pkg::LUT_IDX_LSB +: vsc_pkg::LUT_IDX_W];
  assign wrVal = (pwdata[7:0] > vsc_pkg::WEIGHT_MAX) ? vsc_pkg::WEIGHT_MAX : pwdata[7:0];
  assign lutWrite = apbWrite && (paddr == vsc_pkg::OFF_LUT);

  generate
    for (genvar e = 0; e < vsc_pkg::LUT_N; e++)
    begin : g_lut
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          hLut[e] <= vsc_pkg::WEIGHT_MAX;
          vLut[e] <= vsc_pkg::WEIGHT_MAX;
        end
        else if (lutWrite && (wrIdx == 6'(e)))
        begin
          if (pwdata[vsc_pkg::LUT_SEL_BIT])
            vLut[e] <= wrVal; // see [RULE_09]
          else
            hLut[e] <= wrVal; // see [RULE_08]
        end
      end
    end
  endgenerate

  logic [vsc_pkg::CR_W-1:0] uvcSum;
  assign uvcSum = (dsPix.sof ? '0 : uVCredit) + uscVStep;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_fifo_capacity: assert property (level <= vsc_pkg::LVL_W'(vsc_pkg::FIFO_DEPTH)) // see [RULE_01]
    else $error("fifo level above capacity");
  a_lock_holds: assert property (headBlocks && !released |-> !fifoPop) // see [RULE_02]
    else $error("locked fifo output popped");
  a_release_level: assert property (!released ##1 released |-> $past(level) > $past(relLevel)) // see [RULE_03]
    else $error("lock released below threshold");
  a_dsc_bypass: assert property (fifoPop && !dscEn |=> dsValid && dsPix == $past(head)) // see [RULE_05]
    else $error("disabled downscaler altered pixel");
  a_dsc_count: assert property (dCnt <= 7'h40) // see [RULE_04]
    else $error("downscale accumulation beyond 64 pixels");
  a_mirror_keep: assert property (fifoPop && head.sol && dscMirror |=> lineKeep) // see [RULE_14]
    else $error("line dropped while downscaler mirrors");
  a_usc_bypass: assert property (usState == vsc_pkg::US_EMIT && canEmit && !uscEn
                                 |=> outValid && outData.pix.rgb == $past(uCur.rgb)) // see [RULE_11]
    else $error("disabled upscaler interpolated");
  a_line_restart: assert property (dsTake && dsPix.sol && uscEn
                                   |=> uCredit == $past(uscHStep)) // see [RULE_16]
    else $error("upscale credit not restarted at line");
  a_whole_lines: assert property (dsTake && dsPix.sol && uscEn
                                  |=> 20'(lineRep) * vsc_pkg::PHASE_ONE
                                      + uVCredit == $past(uvcSum)) // see [RULE_13]
    else $error("vertical repeat not whole lines");
  a_lut_range: assert property (hLut[lutIdx] <= vsc_pkg::WEIGHT_MAX
                                && vLut[lutIdx] <= vsc_pkg::WEIGHT_MAX) // see [RULE_09]
    else $error("transition entry above 64");
  a_out_stable: assert property (outValid && !outReady |=> outValid && $stable(outData))
    else $error("output changed under back-pressure");

  c_lock_release: cover property (headBlocks && !released ##[1:200] fifoPop);
  c_upscale_burst: cover property ((usState == vsc_pkg::US_EMIT && canEmit) [*3]);
  c_line_drop: cover property (fifoPop && head.sol && dscEn && !next_lineKeep);
  c_mirror: cover property (outValid && outData.mirror);
endmodule : vsc_scaler

/* dv/vsc_stream_model.sv */
// partner model: upstream pixel source and downstream display sink
module vsc_stream_model (
  input wire logic ref_clk,
  input wire logic rst,
  output logic inValid,
  output vsc_pkg::vsc_pix_t inData,
  input wire logic inReady,
  input wire logic outValid,
  input wire vsc_pkg::vsc_out_t outData,
  output logic outReady
);
  timeunit 1ns;
  timeprecision 1ns;
  vsc_pkg::vsc_pix_t txQ[$];
  logic stall = 1'b0;
  logic sawMirror = 1'b0;
  logic [23:0] matchRgb = 24'h12_3456;
  int rxCount = 0;
  int rxMatch = 0;
  logic [6:0] lastRep = 7'h00;

  task automatic push(input int n, input logic [23:0] rgb, input logic sof, input logic sol);
    vsc_pkg::vsc_pix_t p;
    for (int i = 0; i < n; i++)
    begin
      p.sof = sof && (i == 0);
      p.sol = sol && (i == 0);
      p.rgb = rgb;
      txQ.push_back(p);
    end
  endtask : push

  // offer holds until taken; idle data keeps toggling so stale values never look valid
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      inValid <= 1'b0;
      inData <= '0;
    end
    else if (!inValid || inReady)
    begin
      if (txQ.size() > 0)
      begin
        inValid <= 1'b1;
        inData <= txQ.pop_front();
      end
      else
      begin
        inValid <= 1'b0;
        inData <= ~inData;
      end
    end
  end

  // sink may stall every other cycle, like a busy display line store
  always @(posedge ref_clk)
  begin
    outReady <= stall ? ~outReady : 1'b1;
    if (!rst && outValid && outReady)
    begin
      rxCount++;
      if (outData.pix.rgb === matchRgb) rxMatch++;
      if (outData.mirror === 1'b1) sawMirror = 1'b1;
      if (outData.pix.sol === 1'b1) lastRep = outData.vRepeat;
    end
  end
endmodule : vsc_stream_model

/* dv/tb_top.sv */
// self-checking testbench of the video scaler
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic inValid;
  logic inReady;
  logic outValid;
  logic outReady;
  vsc_pkg::vsc_pix_t inData;
  vsc_pkg::vsc_out_t outData;
  int num_errors = 0;
  int total_checks = 0;

  always #50 ref_clk = ~ref_clk;

  vsc_scaler i_vsc_scaler (.ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .inValid(inValid), .inData(inData), .inReady(inReady),
    .outValid(outValid), .outData(outData), .outReady(outReady));
  vsc_stream_model i_vsc_stream_model (.ref_clk(ref_clk), .rst(rst), .inValid(inValid),
    .inData(inData), .inReady(inReady), .outValid(outValid), .outData(outData),
    .outReady(outReady));

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check_val("access cycles", 32'h0000_0001, n);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp,
                        input logic expErr);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    check_val(what, exp, rd);
    check_val("pslverr", {31'h0000_0000, expErr}, {31'h0000_0000, err});
  endtask : rd_chk

  task automatic do_reset();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    i_vsc_stream_model.rxCount = 0;
    i_vsc_stream_model.rxMatch = 0;
    i_vsc_stream_model.sawMirror = 1'b0;
    i_vsc_stream_model.stall = 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : do_reset

  // wait until the output count stays put for a while
  task automatic settle();
    int quiet;
    int last;
    quiet = 0;
    last = -1;
    while (quiet < 60)
    begin
      @(posedge ref_clk);
      if (i_vsc_stream_model.rxCount == last && i_vsc_stream_model.txQ.size() == 0) quiet++;
      else quiet = 0;
      last = i_vsc_stream_model.rxCount;
    end
  endtask : settle

  task automatic t_regs();
    logic [7:0] offs[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
    logic [31:0] vals[6] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0040, 32'h0000_0040,
                             32'h0000_0040, 32'h0000_0040};
    do_reset();
    foreach (offs[i]) rd_chk("reset value", offs[i], vals[i], 1'b0);
    rd_chk("unmapped", 8'h20, 32'h0000_0000, 1'b1);
    wr(8'h04, 32'h0000_00a5);
    rd_chk("threshold", 8'h04, 32'h0000_00a5, 1'b0);
    wr(8'h18, 32'h0000_0564);
    rd_chk("table clamp", 8'h18, 32'h0000_0540, 1'b0);
    wr(8'h18, 32'h0001_0507);
    rd_chk("vertical table", 8'h18, 32'h0001_0507, 1'b0);
    $display("test registers done");
  endtask : t_regs

  task automatic t_lock(input logic lineLock);
    do_reset();
    wr(8'h00, {29'h0000_0000, lineLock, 2'b00});
    wr(8'h04, 32'h0000_0001);
    i_vsc_stream_model.push(8, 24'h12_3456, 1'b1, 1'b1);
    settle();
    check_val("held count", 32'h0000_0000, i_vsc_stream_model.rxCount);
    rd_chk("status", 8'h1c, 32'h0001_0008, 1'b0);
    i_vsc_stream_model.push(1, 24'h12_3456, 1'b0, 1'b0);
    settle();
    check_val("released count", 32'd9, i_vsc_stream_model.rxCount);
    i_vsc_stream_model.push(5, 24'h65_4321, 1'b0, 1'b1);
    settle();
    check_val("next line", lineLock ? 32'd9 : 32'd14, i_vsc_stream_model.rxCount);
    $display("test lock mode %0d done", lineLock);
  endtask : t_lock

  task automatic t_fifo();
    do_reset();
    wr(8'h04, 32'h0000_00ff);
    i_vsc_stream_model.stall = 1'b1;
    i_vsc_stream_model.push(1281, 24'h12_3456, 1'b1, 1'b1);
    settle();
    check_val("full ready", 32'h0000_0000, {31'h0000_0000, inReady});
    rd_chk("full status", 8'h1c, 32'h0001_0500, 1'b0);
    wr(8'h04, 32'h0000_0000);
    settle();
    check_val("drained", 32'd1281, i_vsc_stream_model.rxCount);
    $display("test fifo done");
  endtask : t_fifo

  task automatic t_scale(input logic [31:0] ctrl, input logic [7:0] off, input logic [31:0] v,
                         input int n, input int exp);
    do_reset();
    wr(off, v);
    wr(8'h00, ctrl);
    i_vsc_stream_model.push(n, 24'h12_3456, 1'b1, 1'b1);
    i_vsc_stream_model.push(1, 24'h65_4321, 1'b1, 1'b1);
    settle();
    check_val("scaled count", exp, i_vsc_stream_model.rxMatch);
    check_val("line repeat", 32'h0000_0001, 32'(i_vsc_stream_model.lastRep));
    $display("test scale ctrl %h step %h done", ctrl, v);
  endtask : t_scale

  task automatic t_mirror(input logic [31:0] ctrl, input int exp);
    do_reset();
    wr(8'h0c, 32'h0000_0020);
    wr(8'h00, ctrl);
    i_vsc_stream_model.push(4, 24'h12_3456, 1'b1, 1'b1);
    i_vsc_stream_model.push(4, 24'h12_3456, 1'b0, 1'b1);
    i_vsc_stream_model.push(1, 24'h65_4321, 1'b1, 1'b1);
    settle();
    check_val("mirror lines", exp, i_vsc_stream_model.rxMatch);
    check_val("mirror flag", 32'(ctrl[3] | ctrl[4]), 32'(i_vsc_stream_model.sawMirror));
    $display("test mirror ctrl %h done", ctrl);
  endtask : t_mirror

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    t_regs();
    t_lock(1'b0);
    t_lock(1'b1);
    t_fifo();
    t_scale(32'h0000_0001, 8'h08, 32'h0000_0020, 16, 8);
    t_scale(32'h0000_0000, 8'h08, 32'h0000_0020, 16, 16);
    t_scale(32'h0000_0001, 8'h08, 32'h0000_0001, 64, 1);
    t_scale(32'h0000_0002, 8'h10, 32'h0000_0080, 8, 16);
    t_scale(32'h0000_0000, 8'h10, 32'h0000_0080, 8, 8);
    t_scale(32'h0000_0002, 8'h10, 32'h0000_1000, 2, 128);
    t_scale(32'h0000_0002, 8'h10, 32'h0032_0050, 4, 5);
    t_mirror(32'h0000_0001, 4);
    t_mirror(32'h0000_0009, 8);
    t_mirror(32'h0000_0011, 4);
    tally_and_finish();
  end

  initial
  begin
    #5_000_000;
    num_errors++;
    tally_and_finish();
  end
endmodule : tb_top
